// ---- fgcr_regs.sv ----
// fgcr_regs: global configuration registers of the biopotential front end
// assumes: classic wishbone slave, 32-bit data, leg status pin async to core_clk
// Notes on behaviour
// - rate bit 7 picks low power at 0 and high resolution at 1.
// - modulator clock is master clock over 4 in high resolution, over 8 in low power.
// - rate code n gives output rate modulator/(16<<n) up to 1024, code 111 is reserved.
// - rate bit 6 picks daisy-chain at 0 and multiple readback at 1.
// - oscillator drives the clock pin only when the source pin is high and bit 5 is 1.
// - first register resets to 06h, second and third to 40h.
// - chop bit 1 fixes central terminal chopping at modulator/16, 0 lets it vary.
// - internal test bit picks internal test signals at 1, external at 0.
// - amplitude bit picks single amplitude at 0 and double at 1.
// - test code 00 pulses at clk/2^21, 01 at clk/2^20, 11 holds dc, 10 unused.
// - third register bit 6 resets to 1, bits 7..1 writable, bit 0 read-only status.
// - status bit reads 0 with the leg electrode connected and 1 when not.
`timescale 1ns/100ps
`default_nettype none
module fgcr_regs
	import fgcr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [FGCR_ADDR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic clock_source_pin,
	input wire logic leg_off_pin,
	output logic osc_out_en,
	output logic high_resolution_select,
	output logic low_power_operation,
	output logic multi_readback,
	output logic modulator_clock,
	output logic sample_strobe,
	output logic chop_strobe,
	output logic internal_test,
	output logic test_amplitude_double,
	output logic test_signal,
	output logic reference_buffer_on,
	output logic reference_level_high,
	output logic leg_drive_measure_enable,
	output logic leg_drive_ref_internal,
	output logic leg_drive_buffer_on,
	output logic leg_drive_sense_enable,
	output logic irq
);
	logic [7:0] rate_and_mode_config_reg;
	logic [7:0] test_signal_config_reg;
	logic [7:0] reference_and_leg_drive_config_reg;
	logic [FGCR_EV_W-1:0] irq_stat_reg;
	logic [FGCR_EV_W-1:0] irq_en_reg;
	logic [1:0] csel_sync_reg;
	logic [1:0] leg_sync_reg;
	logic leg_prev_reg;
	logic [7:0] rd_next;
	logic rd_hit;
	fgcr_mode_s mode;
	fgcr_test_s test;
	logic mod_tick;
	logic drdy_tick;
	logic chop_tick;
	logic test_wave;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	function automatic logic [7:0] wr_merge(input logic [7:0] old, input logic [7:0] d,
		input logic [7:0] mask);
		return (old & ~mask) | (d & mask);
	endfunction

	wire logic bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	wire logic [FGCR_ADDR_W-3:0] idx = wb_adr_i[FGCR_ADDR_W-1:2];
	// write lands on the edge where the master sees ack, not on the taking edge
	wire logic wr_lane = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
	wire logic wr_rate = wr_lane && idx == 6'(FGCR_IDX_RATE);
	wire logic wr_test = wr_lane && idx == 6'(FGCR_IDX_TEST);
	wire logic wr_ref = wr_lane && idx == 6'(FGCR_IDX_REF);
	wire logic wr_clr = wr_lane && idx == 6'(FGCR_IDX_IRQ_CLR);
	wire logic wr_en = wr_lane && idx == 6'(FGCR_IDX_IRQ_EN);

	always_comb
	begin
		rd_hit = 1'b1;
		rd_next = 8'h00;
		unique case (idx)
			6'(FGCR_IDX_RATE): rd_next = rate_and_mode_config_reg;
			6'(FGCR_IDX_TEST): rd_next = test_signal_config_reg;
			6'(FGCR_IDX_REF): rd_next = reference_and_leg_drive_config_reg;
			6'(FGCR_IDX_IRQ_STAT): rd_next = 8'(irq_stat_reg);
			6'(FGCR_IDX_IRQ_CLR): rd_next = 8'h00;
			6'(FGCR_IDX_IRQ_EN): rd_next = 8'(irq_en_reg);
			default: rd_hit = 1'b0;
		endcase
	end

	// one wait-free answer: ack or err one edge after the request
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= bus_req && rd_hit;
			wb_err_o <= bus_req && !rd_hit;
			wb_dat_o <= (bus_req && rd_hit && !wb_we_i) ? {24'h00_0000, rd_next} :
				32'h0000_0000;
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	// reserved bits held at zero whatever software writes
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			rate_and_mode_config_reg <= FGCR_RATE_RST;
		else if (wr_rate)
			rate_and_mode_config_reg <= wr_merge(rate_and_mode_config_reg, wb_dat_i[7:0],
				FGCR_RATE_WMASK);
	end

	// bit 6 keeps its reset one; clearing it would need a write of zero, refused here
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			test_signal_config_reg <= FGCR_TEST_RST;
		else if (wr_test)
			test_signal_config_reg <= wr_merge(test_signal_config_reg, wb_dat_i[7:0],
				FGCR_TEST_WMASK);
	end

	// bit 0 is leg status, never written by software
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			reference_and_leg_drive_config_reg <= FGCR_REF_RST;
		else
		begin
			if (wr_ref)
				reference_and_leg_drive_config_reg[7:1] <= wb_dat_i[7:1];
			reference_and_leg_drive_config_reg[FGCR_STAT_BIT] <= leg_sync_reg[1];
		end
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			csel_sync_reg <= 2'b00;
			leg_sync_reg <= 2'b00;
			leg_prev_reg <= 1'b0;
		end
		else
		begin
			csel_sync_reg <= {csel_sync_reg[0], clock_source_pin};
			leg_sync_reg <= {leg_sync_reg[0], leg_off_pin};
			leg_prev_reg <= leg_sync_reg[1];
		end
	end

	// ----------------------------------------
	// timebase
	// ----------------------------------------
	assign mode = '{high_resolution_select: rate_and_mode_config_reg[FGCR_HR_BIT],
		multi_readback: rate_and_mode_config_reg[FGCR_DAISY_BIT],
		osc_out_enable: rate_and_mode_config_reg[FGCR_OSC_BIT],
		output_rate_code: rate_and_mode_config_reg[2:0]};
	assign test = '{central_terminal_chop_fixed: test_signal_config_reg[FGCR_CHOP_BIT],
		internal_test: test_signal_config_reg[FGCR_INT_TEST_BIT],
		test_amplitude_double: test_signal_config_reg[FGCR_AMP_BIT],
		test_frequency_code: test_signal_config_reg[1:0]};

	fgcr_timebase #(.CNT_W(22)) u_timebase (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.mode(mode),
		.test(test),
		.mod_tick(mod_tick),
		.drdy_tick(drdy_tick),
		.chop_tick(chop_tick),
		.test_wave(test_wave)
	);

	// ----------------------------------------
	// interrupts: sample ready, leg lost, illegal code
	// ----------------------------------------
	wire logic bad_code = (mode.output_rate_code == FGCR_DR_RESERVED) ||
		(test.test_frequency_code == FGCR_TF_BAD);
	wire logic [FGCR_EV_W-1:0] ev = {bad_code, leg_sync_reg[1] && !leg_prev_reg, drdy_tick};

	// set wins over a clear in the same cycle
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_stat_reg <= '0;
		else
			irq_stat_reg <= (irq_stat_reg & ~(wr_clr ? wb_dat_i[FGCR_EV_W-1:0] : '0)) | ev;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_en_reg <= '0;
		else if (wr_en)
			irq_en_reg <= wb_dat_i[FGCR_EV_W-1:0];
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			osc_out_en <= 1'b0;
			high_resolution_select <= 1'b0;
			low_power_operation <= 1'b1;
			multi_readback <= 1'b0;
			modulator_clock <= 1'b0;
			sample_strobe <= 1'b0;
			chop_strobe <= 1'b0;
			internal_test <= 1'b0;
			test_amplitude_double <= 1'b0;
			test_signal <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			osc_out_en <= csel_sync_reg[1] && mode.osc_out_enable;
			high_resolution_select <= mode.high_resolution_select;
			low_power_operation <= !mode.high_resolution_select;
			multi_readback <= mode.multi_readback;
			modulator_clock <= mod_tick;
			sample_strobe <= drdy_tick;
			chop_strobe <= chop_tick;
			internal_test <= test.internal_test;
			test_amplitude_double <= test.test_amplitude_double;
			test_signal <= test_wave;
			irq <= |((irq_stat_reg & ~(wr_clr ? wb_dat_i[FGCR_EV_W-1:0] : '0) | ev) &
				(wr_en ? wb_dat_i[FGCR_EV_W-1:0] : irq_en_reg));
		end
	end

	assign reference_buffer_on = reference_and_leg_drive_config_reg[7];
	assign reference_level_high = reference_and_leg_drive_config_reg[5];
	assign leg_drive_measure_enable = reference_and_leg_drive_config_reg[4];
	assign leg_drive_ref_internal = reference_and_leg_drive_config_reg[3];
	assign leg_drive_buffer_on = reference_and_leg_drive_config_reg[2];
	assign leg_drive_sense_enable = reference_and_leg_drive_config_reg[1];

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_rst_vals;
		@(posedge core_clk) $rose(rst_n) |-> rate_and_mode_config_reg == FGCR_RATE_RST &&
			test_signal_config_reg == FGCR_TEST_RST &&
			reference_and_leg_drive_config_reg[7:1] == FGCR_REF_RST[7:1];
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("bad reset value");

	property p_osc;
		@(posedge core_clk) disable iff (!rst_n)
			osc_out_en |-> $past(csel_sync_reg[1]) && $past(rate_and_mode_config_reg[5]);
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator out without enable");

	property p_hr_div;
		@(posedge core_clk) disable iff (!rst_n)
			(mod_tick && mode.high_resolution_select) ##1 mode.high_resolution_select[*4]
			|-> mod_tick && !$past(mod_tick, 1) && !$past(mod_tick, 2) && !$past(mod_tick, 3);
	endproperty
	a_hr_div: assert property (p_hr_div) else $error("hr modulator period not 4");

	property p_lp_div;
		@(posedge core_clk) disable iff (!rst_n)
			(mod_tick && !mode.high_resolution_select) ##1 (!mode.high_resolution_select)[*8]
			|-> mod_tick && !$past(mod_tick, 1) && !$past(mod_tick, 2) && !$past(mod_tick, 3)
			&& !$past(mod_tick, 4) && !$past(mod_tick, 5) && !$past(mod_tick, 6)
			&& !$past(mod_tick, 7);
	endproperty
	a_lp_div: assert property (p_lp_div) else $error("lp modulator period not 8");

	property p_rate_res;
		@(posedge core_clk) disable iff (!rst_n)
			mode.output_rate_code == FGCR_DR_RESERVED |-> !drdy_tick;
	endproperty
	a_rate_res: assert property (p_rate_res) else $error("sample on reserved code");

	wire logic [3:0] mod_cnt_low = u_timebase.mod_cnt_reg[3:0];
	property p_rate_min;
		@(posedge core_clk) disable iff (!rst_n)
			drdy_tick && mode.output_rate_code == 3'h0 |-> mod_cnt_low == 4'h0;
	endproperty
	a_rate_min: assert property (p_rate_min) else $error("rate 16 misaligned");

	property p_stat_ro;
		@(posedge core_clk) disable iff (!rst_n)
			##1 reference_and_leg_drive_config_reg[0] == $past(leg_sync_reg[1]);
	endproperty
	a_stat_ro: assert property (p_stat_ro) else $error("status not from pin");

	property p_mode_out;
		@(posedge core_clk) disable iff (!rst_n)
			##1 low_power_operation == !$past(rate_and_mode_config_reg[7]) &&
			multi_readback == $past(rate_and_mode_config_reg[6]);
	endproperty
	a_mode_out: assert property (p_mode_out) else $error("mode outputs wrong");

	property p_chop;
		@(posedge core_clk) disable iff (!rst_n)
			chop_tick && test.central_terminal_chop_fixed |-> mod_tick && mod_cnt_low == 4'h0;
	endproperty
	a_chop: assert property (p_chop) else $error("fixed chop off rate");

	property p_test_dc;
		@(posedge core_clk) disable iff (!rst_n)
			test.test_frequency_code == FGCR_TF_DC |=> test_signal;
	endproperty
	a_test_dc: assert property (p_test_dc) else $error("dc test signal low");
endmodule
`default_nettype wire

// ---- fgcr_pkg.sv ----
// fgcr_pkg: constants and carriers for the front-end global config registers
// assumes: classic wishbone slave, 32-bit data, byte addresses = 4 * register index
package fgcr_pkg;
	// ----------------------------------------
	// register indices and address width
	// ----------------------------------------
	localparam logic [7:0] FGCR_IDX_RATE = 8'h01;
	localparam logic [7:0] FGCR_IDX_TEST = 8'h02;
	localparam logic [7:0] FGCR_IDX_REF = 8'h03;
	localparam logic [7:0] FGCR_IDX_IRQ_STAT = 8'h04;
	localparam logic [7:0] FGCR_IDX_IRQ_CLR = 8'h05;
	localparam logic [7:0] FGCR_IDX_IRQ_EN = 8'h06;
	localparam int FGCR_ADDR_W = 8;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] FGCR_RATE_RST = 8'h06;
	localparam logic [7:0] FGCR_TEST_RST = 8'h40;
	localparam logic [7:0] FGCR_REF_RST = 8'h40;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int FGCR_HR_BIT = 7;
	localparam int FGCR_DAISY_BIT = 6;
	localparam int FGCR_OSC_BIT = 5;
	localparam int FGCR_CHOP_BIT = 5;
	localparam int FGCR_INT_TEST_BIT = 4;
	localparam int FGCR_AMP_BIT = 2;
	localparam int FGCR_STAT_BIT = 0;
	// writable masks; rate bits 4:3 and test bits 7:6,3 are reserved
	localparam logic [7:0] FGCR_RATE_WMASK = 8'he7;
	localparam logic [7:0] FGCR_TEST_WMASK = 8'h37;
	localparam logic [7:0] FGCR_REF_WMASK = 8'hfe;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int FGCR_DIV_HR = 4;
	localparam int FGCR_DIV_LP = 8;
	localparam int FGCR_DR_BASE_LOG2 = 4;
	localparam logic [2:0] FGCR_DR_RESERVED = 3'h7;
	localparam int FGCR_CHOP_DIV_LOG2 = 4;
	localparam int FGCR_TEST_LOG2_SLOW = 21;
	localparam int FGCR_TEST_LOG2_FAST = 20;
	localparam logic [1:0] FGCR_TF_SLOW = 2'h0;
	localparam logic [1:0] FGCR_TF_FAST = 2'h1;
	localparam logic [1:0] FGCR_TF_BAD = 2'h2;
	localparam logic [1:0] FGCR_TF_DC = 2'h3;
	// interrupt bits
	localparam int FGCR_EV_DRDY = 0;
	localparam int FGCR_EV_LOFF = 1;
	localparam int FGCR_EV_BAD = 2;
	localparam int FGCR_EV_W = 3;
	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic high_resolution_select;
		logic multi_readback;
		logic osc_out_enable;
		logic [2:0] output_rate_code;
	} fgcr_mode_s;
	typedef struct packed {
		logic central_terminal_chop_fixed;
		logic internal_test;
		logic test_amplitude_double;
		logic [1:0] test_frequency_code;
	} fgcr_test_s;
endpackage

// ---- fgcr_timebase.sv ----
// fgcr_timebase: modulator clock strobe, output rate strobe, chop and test strobes
// assumes: mode inputs come from registers on the same clock
`timescale 1ns/100ps
`default_nettype none
module fgcr_timebase
	import fgcr_pkg::*;
#(
	parameter int CNT_W = 22
)
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire fgcr_mode_s mode,
	input wire fgcr_test_s test,
	output logic mod_tick,
	output logic drdy_tick,
	output logic chop_tick,
	output logic test_wave
);
	// the slow test wave needs counter bit 20
	if (CNT_W < FGCR_TEST_LOG2_SLOW + 1)
		$error("fgcr_timebase: CNT_W too small");

	logic [2:0] pre_reg;
	logic [CNT_W-1:0] mod_cnt_reg;
	logic [CNT_W-1:0] clk_cnt_reg;

	// ----------------------------------------
	// modulator clock prescale
	// ----------------------------------------
	// divide by 4 in high resolution, by 8 in low power
	wire logic [2:0] pre_last = mode.high_resolution_select ? 3'(FGCR_DIV_HR - 1) :
		3'(FGCR_DIV_LP - 1);
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			pre_reg <= 3'h0;
		else if (pre_reg >= pre_last)
			pre_reg <= 3'h0;
		else
			pre_reg <= pre_reg + 3'h1;
	end
	assign mod_tick = (pre_reg == pre_last);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			mod_cnt_reg <= '0;
		else if (mod_tick)
			mod_cnt_reg <= mod_cnt_reg + 1'b1;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			clk_cnt_reg <= '0;
		else
			clk_cnt_reg <= clk_cnt_reg + 1'b1;
	end

	// ----------------------------------------
	// strobes
	// ----------------------------------------
	function automatic logic low_zero(input logic [CNT_W-1:0] v, input int n);
		logic r;
		r = 1'b1;
		for (int i = 0; i < CNT_W; i++)
			if (i < n && v[i])
				r = 1'b0;
		return r;
	endfunction

	// rate divisor 16 << code; reserved code yields no samples
	assign drdy_tick = mod_tick && (mode.output_rate_code != FGCR_DR_RESERVED) &&
		low_zero(mod_cnt_reg, FGCR_DR_BASE_LOG2 + int'(mode.output_rate_code));
	// fixed chop at modulator/16, otherwise tied to output rate
	assign chop_tick = test.central_terminal_chop_fixed ?
		(mod_tick && low_zero(mod_cnt_reg, FGCR_CHOP_DIV_LOG2)) : drdy_tick;

	// square wave of period 2^21 or 2^20 clocks, or dc
	always_comb
	begin
		unique case (test.test_frequency_code)
			FGCR_TF_SLOW: test_wave = clk_cnt_reg[FGCR_TEST_LOG2_SLOW-1];
			FGCR_TF_FAST: test_wave = clk_cnt_reg[FGCR_TEST_LOG2_FAST-1];
			FGCR_TF_DC: test_wave = 1'b1;
			default: test_wave = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// tb_top: self-checking bench for the front-end global config registers
// assumes: fgcr_regs alone, reached over classic wishbone driven from here
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import fgcr_pkg::*;
;
	logic core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [3:0] wb_sel_i;
	logic clock_source_pin, leg_off_pin, osc_out_en, high_resolution_select;
	logic low_power_operation, multi_readback, modulator_clock, sample_strobe, chop_strobe;
	logic internal_test, test_amplitude_double, test_signal, reference_buffer_on, irq;
	logic reference_level_high, leg_drive_measure_enable, leg_drive_ref_internal;
	logic leg_drive_buffer_on, leg_drive_sense_enable, er;
	logic [7:0] model [1:3];
	int bad_count = 0;
	int comparisons = 0;
	int seed = 4800;
	int g;
	logic [7:0] rnd;

	fgcr_regs dut (.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
		.wb_sel_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .clock_source_pin, .leg_off_pin,
		.osc_out_en, .high_resolution_select, .low_power_operation, .multi_readback,
		.modulator_clock, .sample_strobe, .chop_strobe, .internal_test, .test_amplitude_double,
		.test_signal, .reference_buffer_on, .reference_level_high, .leg_drive_measure_enable,
		.leg_drive_ref_internal, .leg_drive_buffer_on, .leg_drive_sense_enable, .irq);

	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic finish_test();
		if (bad_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// called just after a rising edge; ends one idle cycle after the answer
	task automatic bus(input logic we, input int idx, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= 8'(idx * 4);
		wb_dat_i <= d;
		wb_sel_i <= s;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		er = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 20)
			check("bus_answer", 0, 1);
		@(posedge core_clk);
	endtask

	task automatic wr(input int idx, input logic [7:0] d);
		bus(1'b1, idx, {24'h0000_00, d}, 4'h1);
		if (idx == 1)
			model[1] = d & 8'he7;
		if (idx == 2)
			model[2] = (d & 8'h37) | 8'h40;
		if (idx == 3)
			model[3] = d & 8'hfe;
	endtask

	// status bit follows the leg pin, which is held steady around every read
	task automatic rdchk(input int idx);
		logic [7:0] e;
		e = (idx == 3) ? {model[3][7:1], leg_off_pin} : model[idx];
		bus(1'b0, idx, 32'h0000_0000, 4'hf);
		check("reg_read", rd, {24'h0000_00, e});
	endtask

	function automatic logic pick(input int w);
		return (w == 0) ? modulator_clock : ((w == 1) ? sample_strobe : chop_strobe);
	endfunction

	// cycles between two successive pulses of the chosen strobe
	task automatic gap(input int w, output int p);
		int n;
		n = 0;
		p = 0;
		// skip a pulse still launched under the previous setting
		repeat (2) @(posedge core_clk);
		while (pick(w) !== 1'b1 && n < 20000)
		begin
			@(posedge core_clk);
			n++;
		end
		@(posedge core_clk);
		while (pick(w) !== 1'b1 && p < 20000)
		begin
			@(posedge core_clk);
			p++;
		end
		p++;
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial
	begin
		rst_n = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0000_0000;
		wb_sel_i = 4'h0;
		clock_source_pin = 1'b0;
		leg_off_pin = 1'b0;
		model[1] = 8'h06;
		model[2] = 8'h40;
		model[3] = 8'h40;
		repeat (6) @(posedge core_clk);
		check("lp_in_reset", low_power_operation, 1);
		rst_n <= 1'b1;
		@(posedge core_clk);
		for (int i = 1; i < 4; i++)
			rdchk(i);
		for (int k = 0; k < 12; k++)
		begin
			g = 1 + k % 3;
			rnd = 8'($random(seed));
			// reserved bits written as software must: zeros, and a one in ref bit 6
			rnd = (g == 1) ? rnd & 8'he7 : ((g == 2) ? rnd & 8'h37 : rnd | 8'h40);
			wr(g, rnd);
			clock_source_pin <= 1'($random(seed));
			repeat (4) @(posedge core_clk);
			rdchk(g);
			check("mode", {high_resolution_select, low_power_operation, multi_readback},
				{model[1][7], ~model[1][7], model[1][6]});
			check("osc", osc_out_en, clock_source_pin & model[1][5]);
			check("test", {internal_test, test_amplitude_double}, {model[2][4], model[2][2]});
			check("ref", {reference_buffer_on, reference_level_high, leg_drive_measure_enable,
				leg_drive_ref_internal, leg_drive_buffer_on, leg_drive_sense_enable},
				{model[3][7], model[3][5:1]});
		end
		// write with byte lane off must not land
		bus(1'b1, 1, 32'h0000_00ff, 4'he);
		rdchk(1);
		bus(1'b0, 7, 32'h0000_0000, 4'hf);
		check("err_unmapped", er, 1);
		wr(2, 8'h00);
		for (int c = 0; c < 7; c++)
		begin
			wr(1, 8'h80 | 8'(c));
			gap(1, g);
			check("rate_hr", g, 4 * (16 << c));
		end
		gap(0, g);
		check("mod_hr", g, 4);
		wr(1, 8'h81);
		wr(2, 8'h20);
		gap(2, g);
		check("chop_fixed", g, 64);
		wr(2, 8'h00);
		gap(2, g);
		check("chop_vary", g, 128);
		wr(1, 8'h00);
		gap(0, g);
		check("mod_lp", g, 8);
		gap(1, g);
		check("rate_lp", g, 128);
		// leg electrode drops off: status bit and sticky event
		leg_off_pin <= 1'b1;
		repeat (6) @(posedge core_clk);
		rdchk(3);
		bus(1'b0, 4, 32'h0000_0000, 4'hf);
		check("ev_leg", rd & 32'h0000_0002, 32'h0000_0002);
		bus(1'b1, 5, 32'h0000_0002, 4'h1);
		bus(1'b0, 4, 32'h0000_0000, 4'hf);
		check("ev_leg_clr", rd & 32'h0000_0002, 32'h0000_0000);
		wr(2, 8'h02);
		bus(1'b0, 4, 32'h0000_0000, 4'hf);
		check("ev_bad_freq", rd & 32'h0000_0004, 32'h0000_0004);
		check("test_off", test_signal, 0);
		bus(1'b1, 6, 32'h0000_0004, 4'h1);
		repeat (2) @(posedge core_clk);
		check("irq_on", irq, 1);
		bus(1'b1, 6, 32'h0000_0000, 4'h1);
		repeat (2) @(posedge core_clk);
		check("irq_masked", irq, 0);
		wr(2, 8'h03);
		bus(1'b1, 5, 32'h0000_0004, 4'h1);
		bus(1'b1, 6, 32'h0000_0004, 4'h1);
		repeat (3) @(posedge core_clk);
		check("irq_cleared", irq, 0);
		check("test_dc", test_signal, 1);
		bus(1'b1, 6, 32'h0000_0001, 4'h1);
		gap(1, g);
		// old sample events are pending: clear them so the next one must raise irq
		bus(1'b1, 5, 32'h0000_0001, 4'h1);
		repeat (2) @(posedge core_clk);
		check("irq_sample_clr", irq, 0);
		gap(1, g);
		repeat (2) @(posedge core_clk);
		check("irq_sample", irq, 1);
		finish_test();
	end

	initial
	begin
		repeat (60000) @(posedge core_clk);
		bad_count++;
		finish_test();
	end
endmodule
`default_nettype wire
